// File: design/clock_ready_irq_and_periph_reset.sv
// Clock-ready interrupt flags and fast-bus peripheral reset register
//
// The address map and the address-and-strobe port are this design's own decisions.
`default_nettype none
// Summary of operation
// - External-ready interrupt passes only when enabled
// - Bit 10 enables internal-fast ready interrupt
// - Bit 8 enables internal-slow ready interrupt
// - Clock failure sets bit 7, raises interrupt
// - Clock-fail flag clears only by clear bit
// - PLL lock sets bit 4, write-1 clears
// - External ready sets bit 3, write-1 clears
// - Internal-fast ready sets bit 2, write-1 clears
// - Internal-slow ready sets bit 0, write-1 clears
// - Bits 14,12,11 reset serial, SPI, timer
// - Bit 9 resets the converter
// - Bits 5,4,2 reset ports D, C, A
// - Bit 0 resets alternate-function module
// - Bit 11 enables external-ready interrupt
// - Bit 23 write-1 clears clock-fail flag
// - Bit 12 enables PLL-lock interrupt
module clock_ready_irq_and_periph_reset
  import clk_irq_rst_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_int_slow_osc_ready,
  input wire logic i_int_fast_osc_ready,
  input wire logic i_ext_osc_ready,
  input wire logic i_pll_locked,
  input wire logic i_ext_osc_fail,
  output logic o_clock_irq,
  output logic o_event_irq,
  output periph_resets_t o_periph_resets
);
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    logic [3:0] irq_en;
    logic [31:0] periph_rst;
    logic [4:0] evt_en;
    logic [31:0] rdata;
    logic clock_irq;
    logic event_irq;
    periph_resets_t resets;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;
  logic [4:0] rise;
  logic [4:0] flag_clear;
  logic [4:0] flags;
  logic [4:0] evt_clear;
  logic [4:0] evt_status;
  logic wr_intr;
  logic wr_evt_clr;
  logic [31:0] intr_view;

  // Pins are asynchronous: two stages before any edge logic
  assign rise = state.sync2 & ~state.prev;
  assign wr_intr = i_wr && (i_addr == OFS_CLOCK_INTERRUPT_FLAGS_ENABLES);
  assign wr_evt_clr = i_wr && (i_addr == OFS_READY_EVENT_CLEAR);

  // Write-1 clear strobes for the five flags
  assign flag_clear[0] = wr_intr && i_wdata[BIT_INT_SLOW_CLR];
  assign flag_clear[1] = wr_intr && i_wdata[BIT_INT_FAST_CLR];
  assign flag_clear[2] = wr_intr && i_wdata[BIT_EXT_OSC_CLR];
  assign flag_clear[3] = wr_intr && i_wdata[BIT_PLL_CLR];
  assign flag_clear[4] = wr_intr && i_wdata[BIT_CLOCK_FAIL_CLR];
  assign evt_clear = wr_evt_clr ? i_wdata[4:0] : 5'h00;

  // Flags are set by rising hardware events; the clock-fail flag too
  genvar g;
  generate
    for (g = 0; g < N_FLAGS; g++) begin : g_flags
      sticky_flag u_flag (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_set(rise[g]),
        .i_clear(flag_clear[g]),
        .o_flag(flags[g])
      );
      sticky_flag u_evt (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_set(rise[g]),
        .i_clear(evt_clear[g]),
        .o_flag(evt_status[g])
      );
    end
  endgenerate

  // Read view of the clock interrupt register; clear bits read zero
  always_comb begin
    intr_view = RESET_VALUE_ZERO;
    intr_view[BIT_INT_SLOW_FLAG] = flags[0];
    intr_view[BIT_INT_FAST_FLAG] = flags[1];
    intr_view[BIT_EXT_OSC_FLAG] = flags[2];
    intr_view[BIT_PLL_FLAG] = flags[3];
    intr_view[BIT_CLOCK_FAIL_FLAG] = flags[4];
    intr_view[BIT_INT_SLOW_EN] = state.irq_en[0];
    intr_view[BIT_INT_FAST_EN] = state.irq_en[1];
    intr_view[BIT_EXT_OSC_EN] = state.irq_en[2];
    intr_view[BIT_PLL_EN] = state.irq_en[3];
  end

  always_comb begin
    next_state = state;
    next_state.sync1 = {i_ext_osc_fail, i_pll_locked, i_ext_osc_ready,
                        i_int_fast_osc_ready, i_int_slow_osc_ready};
    next_state.sync2 = state.sync1;
    next_state.prev = state.sync2;
    if (wr_intr) begin
      // Flag bits are read-only; writes to them have no effect
      next_state.irq_en[0] = i_wdata[BIT_INT_SLOW_EN];
      next_state.irq_en[1] = i_wdata[BIT_INT_FAST_EN];
      next_state.irq_en[2] = i_wdata[BIT_EXT_OSC_EN];
      next_state.irq_en[3] = i_wdata[BIT_PLL_EN];
    end
    if (i_wr && (i_addr == OFS_FAST_BUS_PERIPHERAL_RESET)) begin
      next_state.periph_rst = i_wdata & PERIPH_RESET_MASK;
    end
    if (i_wr && (i_addr == OFS_READY_EVENT_ENABLE)) begin
      next_state.evt_en = i_wdata[4:0];
    end
    next_state.rdata = RESET_VALUE_ZERO;
    if (i_rd) begin
      unique case (i_addr)
        OFS_CLOCK_INTERRUPT_FLAGS_ENABLES: next_state.rdata = intr_view;
        OFS_FAST_BUS_PERIPHERAL_RESET: next_state.rdata = state.periph_rst;
        OFS_READY_EVENT_STATUS: next_state.rdata = {27'h0, evt_status};
        OFS_READY_EVENT_ENABLE: next_state.rdata = {27'h0, state.evt_en};
        default: next_state.rdata = RESET_VALUE_ZERO;
      endcase
    end
    // Gated OR of ready flags, clock failure always passes
    next_state.clock_irq = (flags[0] & state.irq_en[0])
                         | (flags[1] & state.irq_en[1])
                         | (flags[2] & state.irq_en[2])
                         | (flags[3] & state.irq_en[3])
                         | flags[4];
    next_state.event_irq = |(evt_status & state.evt_en);
    // Module resets held while their bits are 1
    next_state.resets.serial_port_reset = state.periph_rst[BIT_SERIAL_PORT_RST];
    next_state.resets.spi_module_reset = state.periph_rst[BIT_SPI_MODULE_RST];
    next_state.resets.advanced_timer_reset = state.periph_rst[BIT_ADVANCED_TIMER_RST];
    next_state.resets.converter_reset = state.periph_rst[BIT_CONVERTER_RST];
    next_state.resets.port_d_reset = state.periph_rst[BIT_PORT_D_RST];
    next_state.resets.port_c_reset = state.periph_rst[BIT_PORT_C_RST];
    next_state.resets.port_a_reset = state.periph_rst[BIT_PORT_A_RST];
    next_state.resets.alt_function_reset = state.periph_rst[BIT_ALT_FUNCTION_RST];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_rdata = state.rdata;
  assign o_clock_irq = state.clock_irq;
  assign o_event_irq = state.event_irq;
  assign o_periph_resets = state.resets;
endmodule
`default_nettype wire

// File: design/sticky_flag.sv
// One sticky event flag: set by hardware, cleared by a clear strobe
`default_nettype none
module sticky_flag (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);
  typedef struct packed {
    logic flag;
  } sticky_state_t;
  sticky_state_t state;
  sticky_state_t next_state;

  always_comb begin
    next_state = state;
    // Set wins over a clear in the same cycle
    if (i_clear) begin
      next_state.flag = 1'b0;
    end
    if (i_set) begin
      next_state.flag = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_flag = state.flag;
endmodule
`default_nettype wire

// File: pkg/clk_irq_rst_pkg.sv
// Package with register map, field positions and carrier types
`default_nettype none
package clk_irq_rst_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CLOCK_INTERRUPT_FLAGS_ENABLES = 8'h08;
  localparam logic [7:0] OFS_FAST_BUS_PERIPHERAL_RESET = 8'h0C;
  localparam logic [7:0] OFS_READY_EVENT_STATUS = 8'h40;
  localparam logic [7:0] OFS_READY_EVENT_CLEAR = 8'h44;
  localparam logic [7:0] OFS_READY_EVENT_ENABLE = 8'h48;
  // Flag bits
  localparam int BIT_INT_SLOW_FLAG = 0;
  localparam int BIT_INT_FAST_FLAG = 2;
  localparam int BIT_EXT_OSC_FLAG = 3;
  localparam int BIT_PLL_FLAG = 4;
  localparam int BIT_CLOCK_FAIL_FLAG = 7;
  // Enable bits
  localparam int BIT_INT_SLOW_EN = 8;
  localparam int BIT_INT_FAST_EN = 10;
  localparam int BIT_EXT_OSC_EN = 11;
  localparam int BIT_PLL_EN = 12;
  // Clear bits
  localparam int BIT_INT_SLOW_CLR = 16;
  localparam int BIT_INT_FAST_CLR = 18;
  localparam int BIT_EXT_OSC_CLR = 19;
  localparam int BIT_PLL_CLR = 20;
  localparam int BIT_CLOCK_FAIL_CLR = 23;
  // Peripheral reset bits
  localparam int BIT_ALT_FUNCTION_RST = 0;
  localparam int BIT_PORT_A_RST = 2;
  localparam int BIT_PORT_C_RST = 4;
  localparam int BIT_PORT_D_RST = 5;
  localparam int BIT_CONVERTER_RST = 9;
  localparam int BIT_ADVANCED_TIMER_RST = 11;
  localparam int BIT_SPI_MODULE_RST = 12;
  localparam int BIT_SERIAL_PORT_RST = 14;
  localparam logic [31:0] PERIPH_RESET_MASK = 32'h00005A35;
  localparam logic [31:0] RESET_VALUE_ZERO = 32'h00000000;
  localparam int N_FLAGS = 5;

  // Flag order in vectors: slow, fast, ext, pll, clock fail
  typedef struct packed {
    logic clock_fail;
    logic pll_lock;
    logic ext_osc;
    logic int_fast;
    logic int_slow;
  } clk_events_t;

  typedef struct packed {
    logic serial_port_reset;
    logic spi_module_reset;
    logic advanced_timer_reset;
    logic converter_reset;
    logic port_d_reset;
    logic port_c_reset;
    logic port_a_reset;
    logic alt_function_reset;
  } periph_resets_t;
endpackage
`default_nettype wire

// File: verif/clock_ready_irq_and_periph_reset_assertions.sv
// Concurrent checks on the clock-ready interrupt and peripheral reset block
`default_nettype none
module clock_ready_irq_and_periph_reset_assertions
  import clk_irq_rst_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_int_slow_osc_ready,
  input wire logic i_int_fast_osc_ready,
  input wire logic i_ext_osc_ready,
  input wire logic i_pll_locked,
  input wire logic i_ext_osc_fail,
  input wire logic o_clock_irq,
  input wire logic o_event_irq,
  input wire periph_resets_t o_periph_resets
);
  logic pw;
  periph_resets_t pexp;
  assign pw = i_wr && i_addr == OFS_FAST_BUS_PERIPHERAL_RESET;
  // Reset lines in output order, gathered from their write data bits
  assign pexp = {i_wdata[14], i_wdata[12], i_wdata[11], i_wdata[9],
                 i_wdata[5], i_wdata[4], i_wdata[2], i_wdata[0]};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h00000000)
    else $error("read data not zero outside read cycle");
  a_clock_reserved: assert property (
    $past(i_rd && i_addr == OFS_CLOCK_INTERRUPT_FLAGS_ENABLES) |-> (o_rdata & 32'hFFFFE262) == 0)
    else $error("clock register reserved or clear bit reads nonzero");
  a_periph_reserved: assert property (
    $past(i_rd && i_addr == OFS_FAST_BUS_PERIPHERAL_RESET) |-> (o_rdata & 32'hFFFFA5CA) == 0)
    else $error("peripheral reset reserved bit reads nonzero");
  a_periph_write: assert property (
    pw |-> ##2 o_periph_resets == $past(pexp, 2))
    else $error("peripheral reset lines differ from written bits");
  a_periph_hold: assert property (
    $changed(o_periph_resets) |-> $past(pw, 2) || $past(i_srst))
    else $error("peripheral reset lines changed without a write");
  a_fail_raise: assert property ($rose(i_ext_osc_fail) |-> ##[1:5] o_clock_irq)
    else $error("clock failure did not raise the interrupt");
  a_irq_sticky: assert property (
    $fell(o_clock_irq) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_srst))
    else $error("clock interrupt dropped without a register write");
  a_reset_quiet: assert property (
    $fell(i_srst) |-> !o_clock_irq && !o_event_irq && o_periph_resets == 8'h00)
    else $error("outputs not idle after reset");
  c_fail_clear: cover property (i_wr && i_wdata[23]);
  c_clock_irq: cover property ($rose(o_clock_irq));
  c_event_irq: cover property ($rose(o_event_irq));
endmodule
bind clock_ready_irq_and_periph_reset clock_ready_irq_and_periph_reset_assertions u_chk (
  .i_clk_sys, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_int_slow_osc_ready,
  .i_int_fast_osc_ready, .i_ext_osc_ready, .i_pll_locked, .i_ext_osc_fail, .o_clock_irq,
  .o_event_irq, .o_periph_resets);
`default_nettype wire

// File: verif/clock_ready_irq_and_periph_reset_tb.sv
// Self-checking bench for clock-ready flags and peripheral reset register
`default_nettype none
module clock_ready_irq_and_periph_reset_tb
  import clk_irq_rst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 0, i_srst = 1, i_wr = 0, i_rd = 0, o_clock_irq, o_event_irq;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [31:0] i_wdata = '0, o_rdata, em;
  logic [4:0] pins = '0;
  periph_resets_t o_periph_resets;
  int fail_count = 0, check_count = 0;
  int fb[5] = '{0, 2, 3, 4, 7};
  int cb[5] = '{16, 18, 19, 20, 23};
  int eb[5] = '{8, 10, 11, 12, 0};
  int pb[8] = '{0, 2, 4, 5, 9, 11, 12, 14};
  clock_ready_irq_and_periph_reset u_dut (.i_clk_sys, .i_srst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_int_slow_osc_ready(pins[0]), .i_int_fast_osc_ready(pins[1]),
    .i_ext_osc_ready(pins[2]), .i_pll_locked(pins[3]), .i_ext_osc_fail(pins[4]),
    .o_clock_irq, .o_event_irq, .o_periph_resets);
  initial forever #2 i_clk_sys = ~i_clk_sys;
  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    rd(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, 32'h0);
    rd(OFS_FAST_BUS_PERIPHERAL_RESET, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0);
    wr(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, 32'hFFFFFFFF);
    rd(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, 32'h00001D00);
    wr(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, 32'h0);
    wr(OFS_FAST_BUS_PERIPHERAL_RESET, 32'hFFFFFFFF);
    rd(OFS_FAST_BUS_PERIPHERAL_RESET, 32'h00005A35);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_FAST_BUS_PERIPHERAL_RESET, 32'h1 << pb[i]);
      idle(2);
      chk({24'h0, o_periph_resets}, 32'h1 << i);
    end
    wr(OFS_FAST_BUS_PERIPHERAL_RESET, 32'h0);
    for (int k = 0; k < 5; k++) begin
      em = (k < 4) ? 32'h1 << eb[k] : 32'h0;
      @(posedge i_clk_sys);
      pins[k] <= 1'b1;
      idle(6);
      rd(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, 32'h1 << fb[k]);
      rd(OFS_READY_EVENT_STATUS, 32'h1 << k);
      chk({31'h0, o_clock_irq}, 32'(k == 4));
      chk({31'h0, o_event_irq}, 32'h0);
      wr(OFS_READY_EVENT_ENABLE, 32'h1 << k);
      rd(OFS_READY_EVENT_ENABLE, 32'h1 << k);
      wr(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, em | (32'h1 << fb[k]));
      idle(3);
      rd(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, em | (32'h1 << fb[k]));
      chk({31'h0, o_clock_irq}, 32'h1);
      chk({31'h0, o_event_irq}, 32'h1);
      wr(OFS_READY_EVENT_CLEAR, 32'h1 << k);
      wr(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, em | (32'h1 << cb[k]));
      idle(3);
      rd(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, em);
      rd(OFS_READY_EVENT_STATUS, 32'h0);
      chk({31'h0, o_clock_irq}, 32'h0);
      chk({31'h0, o_event_irq}, 32'h0);
      @(posedge i_clk_sys);
      pins[k] <= 1'b0;
      wr(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, 32'h0);
      wr(OFS_READY_EVENT_ENABLE, 32'h0);
    end
    // Reset in mid-run must drop every module reset line
    wr(OFS_FAST_BUS_PERIPHERAL_RESET, 32'hFFFFFFFF);
    idle(2);
    chk({24'h0, o_periph_resets}, 32'h000000FF);
    @(posedge i_clk_sys);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    idle(2);
    chk({24'h0, o_periph_resets}, 32'h0);
    chk({31'h0, o_clock_irq}, 32'h0);
    rd(OFS_FAST_BUS_PERIPHERAL_RESET, 32'h0);
    rd(OFS_CLOCK_INTERRUPT_FLAGS_ENABLES, 32'h0);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
